/* core/tpg_pkg.sv */
// tpg_pkg: constants and types for the output test pattern generator.
// assumes a classic wishbone slave with byte-wide registers at word addresses.
package tpg_pkg;
	localparam int          ADDR_W        = 14;
	localparam int          WORD_W        = 16;
	// printed offsets are register indices; byte address is four times the index
	localparam logic [11:0] IDX_CONTROL   = 12'h550;
	localparam logic [11:0] IDX_PAT_FIRST = 12'h551;
	localparam logic [11:0] IDX_PAT_LAST  = 12'h558;
	localparam logic [7:0]  CONTROL_RESET = 8'h00;
	localparam logic [7:0]  CONTROL_WMASK = 8'hBF;
	localparam int          BIT_ONESHOT   = 7;
	localparam int          BIT_LONG_RST  = 5;
	localparam int          BIT_SHORT_RST = 4;
	localparam logic [15:0] WORD_MID      = 16'h0000;
	localparam logic [15:0] WORD_POS_FS   = 16'h7FFF;
	localparam logic [15:0] WORD_NEG_FS   = 16'h8000;
	localparam logic [15:0] WORD_CHECK_A  = 16'hAAAA;
	localparam logic [15:0] WORD_CHECK_B  = 16'h5555;
	localparam logic [15:0] WORD_ONES     = 16'hFFFF;
	localparam logic [15:0] WORD_ZEROS    = 16'h0000;
	localparam logic [22:0] LONG_SEED     = 23'h7FFFFF;
	localparam logic [8:0]  SHORT_SEED    = 9'h1FF;
	localparam logic [2:0]  SEQ_DONE      = 3'h4;

	typedef enum logic [3:0] {
		MODE_NORMAL   = 4'b0000,
		MODE_MID      = 4'b0001,
		MODE_POS_FS   = 4'b0010,
		MODE_NEG_FS   = 4'b0011,
		MODE_CHECKER  = 4'b0100,
		MODE_PN_LONG  = 4'b0101,
		MODE_PN_SHORT = 4'b0110,
		MODE_TOGGLE   = 4'b0111,
		MODE_USER     = 4'b1000
	} tpg_mode_type;

	typedef struct packed {
		logic        valid;
		logic [15:0] data;
	} tpg_sample_type;
endpackage

/* core/tpg_gen.sv */
// tpg_gen: test pattern substitution on the converter sample path, wishbone registers.
// assumes samples arrive one per core_clk; the framer takes one per core_clk.
//
// Functional notes
// - four-bit mode selects normal data, midscale, full scales, checker, pn, toggle.
// - mode 1000 outputs the four stored user patterns instead of samples.
// - sequence selection bit only matters in mode 1000.
// - selection clear: patterns one to four, one cycle each, repeating.
// - selection set: patterns one to four once, then all-zero words.
// - long pn generator held in reset while its control bit is one.
// - short pn generator held in reset while its control bit is one.
// - each pattern is two byte registers, low then high, consecutive pairs.
//
// Added by the designer: the Wishbone slave port.
`timescale 1ns/10ps
module tpg_gen (
	// clock and reset
	input  wire logic                  core_clk,
	input  wire logic                  rst_b,
	// wishbone slave
	input  wire logic                  wb_cyc_i,
	input  wire logic                  wb_stb_i,
	input  wire logic                  wb_we_i,
	input  wire logic [13:0]           wb_adr_i,
	input  wire logic [3:0]            wb_sel_i,
	input  wire logic [31:0]           wb_dat_i,
	output logic      [31:0]           wb_dat_o,
	output logic                       wb_ack_o,
	output logic                       wb_err_o,
	// converter sample stream
	input  wire tpg_pkg::tpg_sample_type sample_in,
	// to the output framer
	output tpg_pkg::tpg_sample_type    sample_out
);
	logic [7:0]         control;
	logic [7:0]         next_control;
	logic [7:0]         pat_byte [0:7];
	logic [7:0]         next_pat_byte [0:7];
	logic               ack;
	logic               next_ack;
	logic               err;
	logic               next_err;
	logic [31:0]        rdata;
	logic [31:0]        next_rdata;
	logic [22:0]        long_pn;
	logic [22:0]        next_long_pn;
	logic [8:0]         short_pn;
	logic [8:0]         next_short_pn;
	logic               phase;
	logic               next_phase;
	logic [2:0]         seq;
	logic [2:0]         next_seq;
	tpg_pkg::tpg_sample_type out_q;
	tpg_pkg::tpg_sample_type next_out;
	logic [15:0]        user_word [0:3];

	wire logic [11:0] idx     = wb_adr_i[13:2];
	wire logic        req     = wb_cyc_i && wb_stb_i && !ack && !err;
	wire logic        hit_ctl = (idx == tpg_pkg::IDX_CONTROL);
	wire logic        hit_pat = (idx >= tpg_pkg::IDX_PAT_FIRST) && (idx <= tpg_pkg::IDX_PAT_LAST);
	wire logic [2:0]  pat_sel = 3'(idx - tpg_pkg::IDX_PAT_FIRST);
	wire logic [3:0]  mode    = control[3:0];
	wire logic        oneshot = control[tpg_pkg::BIT_ONESHOT];

	// pattern n low byte at even slot, high byte at odd slot
	genvar gi;
	generate
		for (gi = 0; gi < 4; gi++) begin : g_user
			assign user_word[gi] = {pat_byte[2*gi+1], pat_byte[2*gi]};
		end
	endgenerate

	assign wb_ack_o   = ack;
	assign wb_err_o   = err;
	assign wb_dat_o   = rdata;
	assign sample_out = out_q;

	// register bus: one-cycle latency, unmapped addresses answer with err
	always_comb begin
		next_control = control;
		for (int i = 0; i < 8; i++) begin
			next_pat_byte[i] = pat_byte[i];
		end
		next_ack   = 1'b0;
		next_err   = 1'b0;
		next_rdata = 32'h00000000;
		if (req) begin
			if (hit_ctl || hit_pat) begin
				next_ack = 1'b1;
				if (wb_we_i && wb_sel_i[0]) begin
					if (hit_ctl) begin
						// bit 6 stays reserved, reads zero
						next_control = wb_dat_i[7:0] & tpg_pkg::CONTROL_WMASK;
					end else begin
						next_pat_byte[pat_sel] = wb_dat_i[7:0];
					end
				end
				if (!wb_we_i) begin
					next_rdata = {24'h000000, hit_ctl ? control : pat_byte[pat_sel]};
				end
			end else begin
				next_err = 1'b1;
			end
		end
	end

	always_ff @(posedge core_clk or negedge rst_b) begin
		if (!rst_b) begin
			control <= tpg_pkg::CONTROL_RESET;
			for (int i = 0; i < 8; i++) begin
				pat_byte[i] <= 8'h00;
			end
			ack   <= 1'b0;
			err   <= 1'b0;
			rdata <= 32'h00000000;
		end else begin
			control <= next_control;
			for (int i = 0; i < 8; i++) begin
				pat_byte[i] <= next_pat_byte[i];
			end
			ack   <= next_ack;
			err   <= next_err;
			rdata <= next_rdata;
		end
	end

	// generators and output word selection
	always_comb begin
		// x^23 + x^18 + 1 and x^9 + x^5 + 1 chosen for maximal length
		if (control[tpg_pkg::BIT_LONG_RST]) begin
			next_long_pn = tpg_pkg::LONG_SEED;
		end else begin
			next_long_pn = {long_pn[21:0], long_pn[22] ^ long_pn[17]};
		end
		if (control[tpg_pkg::BIT_SHORT_RST]) begin
			next_short_pn = tpg_pkg::SHORT_SEED;
		end else begin
			next_short_pn = {short_pn[7:0], short_pn[8] ^ short_pn[4]};
		end
		next_phase = ~phase;
		// sequence restarts whenever the user mode is left, so re-entry starts at pattern one
		if (mode != tpg_pkg::MODE_USER) begin
			next_seq = 3'h0;
		end else if (seq == tpg_pkg::SEQ_DONE) begin
			next_seq = tpg_pkg::SEQ_DONE;
		end else if (seq == 3'h3 && !oneshot) begin
			next_seq = 3'h0;
		end else begin
			next_seq = 3'(seq + 3'h1);
		end
		next_out.valid = sample_in.valid;
		case (mode)
			tpg_pkg::MODE_NORMAL:   next_out.data = sample_in.data;
			tpg_pkg::MODE_MID:      next_out.data = tpg_pkg::WORD_MID;
			tpg_pkg::MODE_POS_FS:   next_out.data = tpg_pkg::WORD_POS_FS;
			tpg_pkg::MODE_NEG_FS:   next_out.data = tpg_pkg::WORD_NEG_FS;
			tpg_pkg::MODE_CHECKER:  next_out.data = phase ? tpg_pkg::WORD_CHECK_B : tpg_pkg::WORD_CHECK_A;
			tpg_pkg::MODE_PN_LONG:  next_out.data = long_pn[15:0];
			tpg_pkg::MODE_PN_SHORT: next_out.data = {short_pn[6:0], short_pn};
			tpg_pkg::MODE_TOGGLE:   next_out.data = phase ? tpg_pkg::WORD_ZEROS : tpg_pkg::WORD_ONES;
			// selection bit is not read here; it acts only through seq, set by the sequence logic above
			tpg_pkg::MODE_USER: begin
				next_out.data = (seq == tpg_pkg::SEQ_DONE) ? tpg_pkg::WORD_ZEROS : user_word[seq[1:0]];
			end
			default:                next_out.data = tpg_pkg::WORD_ZEROS;
		endcase
	end

	always_ff @(posedge core_clk or negedge rst_b) begin
		if (!rst_b) begin
			long_pn  <= tpg_pkg::LONG_SEED;
			short_pn <= tpg_pkg::SHORT_SEED;
			phase    <= 1'b0;
			seq      <= 3'h0;
			out_q    <= '0;
		end else begin
			long_pn  <= next_long_pn;
			short_pn <= next_short_pn;
			phase    <= next_phase;
			seq      <= next_seq;
			out_q    <= next_out;
		end
	end

	// rst_b in the antecedent: the release edge itself must not start an attempt
	a_pass_normal: assert property (@(posedge core_clk) disable iff (!rst_b)
		rst_b && mode == tpg_pkg::MODE_NORMAL |=> sample_out.data == $past(sample_in.data))
		else $error("normal mode did not pass sample");
	a_pos_full: assert property (@(posedge core_clk) disable iff (!rst_b)
		mode == tpg_pkg::MODE_POS_FS |=> sample_out.data == tpg_pkg::WORD_POS_FS)
		else $error("positive full scale word wrong");
	a_user_first: assert property (@(posedge core_clk) disable iff (!rst_b)
		mode == tpg_pkg::MODE_USER && $past(mode) != tpg_pkg::MODE_USER
		|=> sample_out.data == $past(user_word[0]))
		else $error("user sequence did not start at pattern one");
	a_repeat_four: assert property (@(posedge core_clk) disable iff (!rst_b)
		(mode == tpg_pkg::MODE_USER && !oneshot && seq == 3'h3) ##1
		(mode == tpg_pkg::MODE_USER && !oneshot) |-> seq == 3'h0)
		else $error("repeat mode did not wrap after pattern four");
	a_single_zero: assert property (@(posedge core_clk) disable iff (!rst_b)
		(mode == tpg_pkg::MODE_USER && oneshot && seq == tpg_pkg::SEQ_DONE) |=> sample_out.data == 16'h0000)
		else $error("single mode output not zero after sequence");
	a_seq_idle: assert property (@(posedge core_clk) disable iff (!rst_b)
		mode != tpg_pkg::MODE_USER |=> $past(mode) == tpg_pkg::MODE_USER || seq == 3'h0)
		else $error("user sequence advanced outside user mode");
	a_long_held: assert property (@(posedge core_clk) disable iff (!rst_b)
		control[tpg_pkg::BIT_LONG_RST] |=> long_pn == tpg_pkg::LONG_SEED)
		else $error("long generator ran while held");
	a_short_held: assert property (@(posedge core_clk) disable iff (!rst_b)
		control[tpg_pkg::BIT_SHORT_RST] |=> short_pn == tpg_pkg::SHORT_SEED)
		else $error("short generator ran while held");
	a_short_runs: assert property (@(posedge core_clk) disable iff (!rst_b)
		!control[tpg_pkg::BIT_SHORT_RST] && $past(!control[tpg_pkg::BIT_SHORT_RST]) && $past(rst_b)
		|-> short_pn != $past(short_pn))
		else $error("short generator stalled");
	a_pat_write: assert property (@(posedge core_clk) disable iff (!rst_b)
		req && hit_pat && wb_we_i && wb_sel_i[0] |=> pat_byte[$past(pat_sel)] == $past(wb_dat_i[7:0]))
		else $error("pattern byte write lost");
	a_ack_once: assert property (@(posedge core_clk) disable iff (!rst_b)
		wb_ack_o |=> !wb_ack_o)
		else $error("ack held longer than one cycle");

	// fixed and generated words
	a_mid_word: assert property (@(posedge core_clk) disable iff (!rst_b)
		mode == tpg_pkg::MODE_MID |=> sample_out.data == tpg_pkg::WORD_MID)
		else $error("midscale word wrong");

	a_neg_full: assert property (@(posedge core_clk) disable iff (!rst_b)
		mode == tpg_pkg::MODE_NEG_FS |=> sample_out.data == tpg_pkg::WORD_NEG_FS)
		else $error("negative full scale word wrong");

	a_checker_word: assert property (@(posedge core_clk) disable iff (!rst_b)
		mode == tpg_pkg::MODE_CHECKER |=> sample_out.data == tpg_pkg::WORD_CHECK_A || sample_out.data == tpg_pkg::WORD_CHECK_B)
		else $error("checker word wrong");

	a_checker_flip: assert property (@(posedge core_clk) disable iff (!rst_b)
		(mode == tpg_pkg::MODE_CHECKER) ##1 (mode == tpg_pkg::MODE_CHECKER) |=> sample_out.data != $past(sample_out.data))
		else $error("checker word did not alternate");

	a_toggle_word: assert property (@(posedge core_clk) disable iff (!rst_b)
		mode == tpg_pkg::MODE_TOGGLE |=> sample_out.data == tpg_pkg::WORD_ONES || sample_out.data == tpg_pkg::WORD_ZEROS)
		else $error("toggle word wrong");

	a_toggle_flip: assert property (@(posedge core_clk) disable iff (!rst_b)
		(mode == tpg_pkg::MODE_TOGGLE) ##1 (mode == tpg_pkg::MODE_TOGGLE) |=> sample_out.data != $past(sample_out.data))
		else $error("toggle word did not alternate");

	a_pn_long_word: assert property (@(posedge core_clk) disable iff (!rst_b)
		mode == tpg_pkg::MODE_PN_LONG |=> sample_out.data == $past(long_pn[15:0]))
		else $error("long pn word not on output");

	a_pn_short_word: assert property (@(posedge core_clk) disable iff (!rst_b)
		mode == tpg_pkg::MODE_PN_SHORT |=> sample_out.data == {$past(short_pn[6:0]), $past(short_pn)})
		else $error("short pn word not on output");

	a_long_runs: assert property (@(posedge core_clk) disable iff (!rst_b)
		!control[tpg_pkg::BIT_LONG_RST] && $past(!control[tpg_pkg::BIT_LONG_RST]) && $past(rst_b)
		|-> long_pn != $past(long_pn))
		else $error("long generator stalled");

	// user pattern sequencing
	a_user_word: assert property (@(posedge core_clk) disable iff (!rst_b)
		mode == tpg_pkg::MODE_USER && seq != tpg_pkg::SEQ_DONE |=> sample_out.data == $past(user_word[seq[1:0]]))
		else $error("user pattern word wrong");

	a_repeat_order: assert property (@(posedge core_clk) disable iff (!rst_b)
		(mode == tpg_pkg::MODE_USER && seq < 3'h3) ##1 (mode == tpg_pkg::MODE_USER) |-> seq == 3'($past(seq) + 3'h1))
		else $error("user sequence skipped a pattern");

	a_single_stays: assert property (@(posedge core_clk) disable iff (!rst_b)
		(mode == tpg_pkg::MODE_USER && seq == tpg_pkg::SEQ_DONE) ##1 (mode == tpg_pkg::MODE_USER)
		|-> seq == tpg_pkg::SEQ_DONE)
		else $error("single sequence restarted");

	// undefined mode codes still replace the samples
	a_default_zero: assert property (@(posedge core_clk) disable iff (!rst_b)
		rst_b && mode > tpg_pkg::MODE_USER |=> sample_out.data == tpg_pkg::WORD_ZEROS)
		else $error("undefined mode passed samples");

	a_valid_pass: assert property (@(posedge core_clk) disable iff (!rst_b)
		rst_b |=> sample_out.valid == $past(sample_in.valid))
		else $error("sample valid not passed through");

	// register bus
	a_ctl_write: assert property (@(posedge core_clk) disable iff (!rst_b)
		req && hit_ctl && wb_we_i && wb_sel_i[0] |=> control == ($past(wb_dat_i[7:0]) & tpg_pkg::CONTROL_WMASK))
		else $error("control write lost");

	a_ack_mapped: assert property (@(posedge core_clk) disable iff (!rst_b)
		req && (hit_ctl || hit_pat) |=> wb_ack_o && !wb_err_o)
		else $error("mapped access not acknowledged");

	a_err_unmapped: assert property (@(posedge core_clk) disable iff (!rst_b)
		req && !hit_ctl && !hit_pat |=> wb_err_o && !wb_ack_o)
		else $error("unmapped access not refused");

	a_read_data: assert property (@(posedge core_clk) disable iff (!rst_b)
		req && hit_pat && !wb_we_i |=> wb_dat_o == {24'h000000, $past(pat_byte[pat_sel])})
		else $error("pattern byte read wrong");

	a_idle_data: assert property (@(posedge core_clk) disable iff (!rst_b)
		!wb_ack_o |-> wb_dat_o == 32'h00000000)
		else $error("read data not zero without ack");
endmodule // tpg_gen

/* verification/tpg_framer_model.sv */
// tpg_framer_model: stand-in for the output framer, counts valid words taken.
// assumes one word offered per core_clk edge, no back-pressure.
`timescale 1ns/10ps
module tpg_framer_model (
	// clock and reset
	input  wire logic                    core_clk,
	input  wire logic                    rst_b,
	// from the generator
	input  wire tpg_pkg::tpg_sample_type sample_in,
	// to the bench
	output logic [15:0]                  taken
);
	always_ff @(posedge core_clk or negedge rst_b) begin
		if (!rst_b)
			taken <= 16'h0000;
		else if (sample_in.valid)
			taken <= taken + 16'h0001;
	end
endmodule // tpg_framer_model

/* verification/tpg_gen_test.sv */
// tpg_gen_test: self-checking bench for the test pattern generator.
// assumes the design package and the framer model are compiled first.
`timescale 1ns/10ps
`define CHK(nm, e, g) begin comparisons++; if ((g) !== (e)) begin err_total++; \
	$display("MISMATCH %s exp %h got %h", nm, e, g); end end
module tpg_gen_test;
	logic                    core_clk, rst_b, wb_cyc_i, wb_stb_i, wb_we_i, wb_ack_o, wb_err_o;
	logic [13:0]             wb_adr_i;
	logic [3:0]              wb_sel_i;
	logic [15:0]             taken, t0;
	logic [31:0]             wb_dat_i, wb_dat_o;
	tpg_pkg::tpg_sample_type sample_in, sample_out;
	int                      err_total, comparisons;
	logic [15:0]             pat [4] = '{16'h1E01, 16'h2D02, 16'h3C03, 16'h4B04};
	logic [15:0]             a, b, c;

	tpg_gen tpg_gen_i (.core_clk(core_clk), .rst_b(rst_b), .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i),
		.wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i), .wb_sel_i(wb_sel_i), .wb_dat_i(wb_dat_i), .wb_dat_o(wb_dat_o),
		.wb_ack_o(wb_ack_o), .wb_err_o(wb_err_o), .sample_in(sample_in), .sample_out(sample_out));
	tpg_framer_model tpg_framer_model_i (.core_clk(core_clk), .rst_b(rst_b), .sample_in(sample_out), .taken(taken));

	initial begin
		core_clk = 1'b0;
		forever #12.5 core_clk = ~core_clk;
	end
	// valid toggles so a stuck pass-through shows
	always @(posedge core_clk)
		sample_in <= {~sample_in.valid, sample_in.data + 16'h0001};

	task automatic bus(input logic we, input logic [11:0] i, input logic [7:0] d, output logic [7:0] r,
		output logic e);
		int n;
		@(posedge core_clk);
		wb_cyc_i <= 1'b1;
		wb_stb_i <= 1'b1;
		wb_we_i  <= we;
		wb_sel_i <= 4'hF;
		wb_adr_i <= {i, 2'b00};
		wb_dat_i <= {24'h000000, d};
		n = 0;
		do begin
			@(posedge core_clk);
			n++;
		end while (wb_ack_o !== 1'b1 && wb_err_o !== 1'b1 && n < 20);
		if (n >= 20)
			err_total++;
		r = wb_dat_o[7:0];
		e = wb_err_o;
		wb_cyc_i <= 1'b0;
		wb_stb_i <= 1'b0;
	endtask
	task automatic wr(input logic [11:0] i, input logic [7:0] d);
		logic [7:0] r;
		logic       e;
		bus(1'b1, i, d, r, e);
	endtask
	task automatic rchk(input logic [11:0] i, input logic [7:0] x, input logic xe);
		logic [7:0] r;
		logic       e;
		bus(1'b0, i, x, r, e);
		`CHK("read data", x, r)
		`CHK("bus error", xe, e)
	endtask
	// checks the word launched at the last edge, then moves to the next edge
	task automatic look(input logic [15:0] x);
		#1;
		`CHK("word", x, sample_out.data)
		`CHK("valid", ~sample_in.valid, sample_out.valid)
		@(posedge core_clk);
	endtask
	task automatic grab3;
		@(posedge core_clk);
		#1 a = sample_out.data;
		@(posedge core_clk);
		#1 b = sample_out.data;
		@(posedge core_clk);
		#1 c = sample_out.data;
	endtask

	task automatic t_regs;
		rchk(tpg_pkg::IDX_CONTROL, tpg_pkg::CONTROL_RESET, 1'b0);
		rchk(12'h559, 8'h00, 1'b1);
		wr(tpg_pkg::IDX_CONTROL, 8'hF0);
		rchk(tpg_pkg::IDX_CONTROL, 8'hB0, 1'b0);
		wr(tpg_pkg::IDX_CONTROL, 8'h00);
		#1;
		`CHK("normal", sample_in.data - 16'h0001, sample_out.data)
	endtask
	task automatic t_fixed;
		logic [3:0]  m [5] = '{4'h1, 4'h2, 4'h3, 4'h4, 4'h7};
		logic [31:0] w [5] = '{32'h00000000, 32'h7FFF7FFF, 32'h80008000, 32'hAAAA5555, 32'hFFFF0000};
		// bit 7 set throughout: it must not disturb these modes
		for (int k = 0; k < 5; k++) begin
			wr(tpg_pkg::IDX_CONTROL, {4'h8, m[k]});
			grab3();
			`CHK("fixed", 1'b1, (a === w[k][31:16] && b === w[k][15:0]) || (a === w[k][15:0] && b === w[k][31:16]))
		end
	endtask
	task automatic t_pn;
		logic [7:0] hold [2] = '{8'h25, 8'h16};
		logic [7:0] run  [2] = '{8'h15, 8'h26};
		for (int k = 0; k < 2; k++) begin
			wr(tpg_pkg::IDX_CONTROL, hold[k]);
			grab3();
			`CHK("held", 32'hFFFFFFFF, {b, c})
			wr(tpg_pkg::IDX_CONTROL, run[k]);
			grab3();
			`CHK("running", 1'b1, a !== b || b !== c)
		end
	endtask
	task automatic t_user;
		for (int n = 0; n < 4; n++) begin
			wr(tpg_pkg::IDX_PAT_FIRST + 12'(2 * n), pat[n][7:0]);
			wr(tpg_pkg::IDX_PAT_FIRST + 12'(2 * n + 1), pat[n][15:8]);
		end
		rchk(tpg_pkg::IDX_PAT_LAST, 8'h4B, 1'b0);
		wr(tpg_pkg::IDX_CONTROL, 8'h08);
		#1 t0 = taken;
		for (int n = 0; n < 8; n++)
			look(pat[n % 4]);
		#1;
		`CHK("framer count", 16'h0004, taken - t0)
		wr(tpg_pkg::IDX_CONTROL, 8'h00);
		wr(tpg_pkg::IDX_CONTROL, 8'h88);
		for (int n = 0; n < 6; n++)
			look(n < 4 ? pat[n] : tpg_pkg::WORD_ZEROS);
	endtask

	task automatic tally_and_finish;
		$display("comparisons %0d err_total %0d", comparisons, err_total);
		if (err_total == 0 && comparisons > 0)
			$display("Run complete: PASS");
		else
			$display("Run complete: FAIL");
		$finish;
	endtask

	initial begin
		{rst_b, wb_cyc_i, wb_stb_i, wb_we_i, wb_adr_i, wb_sel_i, wb_dat_i} = '0;
		sample_in = '0;
		repeat (6) @(posedge core_clk);
		rst_b <= 1'b1;
		t_regs();
		t_fixed();
		t_pn();
		t_user();
		tally_and_finish();
	end
	initial begin
		#100000;
		err_total++;
		tally_and_finish();
	end
endmodule // tpg_gen_test
